// file: pkg/qda_pkg.sv
// Shared constants for the quench detect acquisition block
package qda_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned STROBE_HZ     = 720;
  localparam int unsigned STROBE_CYC    = CLK_HZ / STROBE_HZ;
  localparam int unsigned CONV_NS       = 10_000;
  localparam int unsigned CONV_CYC      = CONV_NS / 10;
  localparam int unsigned FETCH_NS      = 80;
  localparam int unsigned FETCH_CYC     = (FETCH_NS + 9) / 10;
  localparam int unsigned ADC_WD_MS     = 1000;
  localparam int unsigned ADC_WD_CYC    = ADC_WD_MS * (CLK_HZ / 1000);
  localparam int unsigned DOUT_WD_MS    = 20;
  localparam int unsigned DOUT_WD_CYC   = DOUT_WD_MS * (CLK_HZ / 1000);
  localparam int unsigned SAMPLE_W      = 16;
  localparam int unsigned STATUS_W      = 8;
  localparam int unsigned WORD_W        = SAMPLE_W + STATUS_W;
  localparam int unsigned NUM_CH        = 8;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned CUR_W         = 16;
  localparam int unsigned NUM_MAG       = 4;
  localparam logic [7:0]  EVT_CLK720    = 8'h01;
  localparam logic [1:0]  GAIN_NORMAL   = 2'h0;
  localparam logic [1:0]  GAIN_QUENCH   = 2'h1;
endpackage : qda_pkg

// file: hw/qda_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module qda_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10:   count <= count + 1'b1;
        2'b01:   count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : qda_fifo
`default_nettype wire

// file: hw/qda_watchdog.sv
// Restartable watchdog that latches expiry
`timescale 1ns/1ps
`default_nettype none
module qda_watchdog #(
  parameter int unsigned TIMEOUT = 100
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic kick_i,
  input  wire logic clear_i,
  output logic      expired_o
);
  logic [31:0] count;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count     <= '0;
      expired_o <= 1'b0;
    end else begin
      if (kick_i) begin
        count <= '0;
      end else if (count < 32'(TIMEOUT)) begin
        count <= count + 32'h1;
      end
      // Expiry wins over clear so a stalled host cannot mask it
      if (!kick_i && count >= 32'(TIMEOUT - 1)) begin
        expired_o <= 1'b1;
      end else if (clear_i) begin
        expired_o <= 1'b0;
      end
    end
  end
endmodule : qda_watchdog
`default_nettype wire

// file: hw/qda_acq.sv
// Quench detect acquisition: timing, ADC scan, FIFO, watchdogs and outputs
`timescale 1ns/1ps
`default_nettype none
module qda_acq
  import qda_pkg::*;
#(
  parameter int unsigned N_CH       = NUM_CH,
  parameter int unsigned N_MAG      = NUM_MAG,
  parameter int unsigned ADC_WD_CY  = ADC_WD_CYC,
  parameter int unsigned DOUT_WD_CY = DOUT_WD_CYC,
  parameter int unsigned STROBE_CY  = STROBE_CYC,
  parameter int unsigned CONV_CY    = CONV_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  // Event link, decoded byte with a strobe from the link receiver pin
  input  wire logic                 evt_valid_i,
  input  wire logic [7:0]           evt_code_i,
  // Real-time value link word stream
  input  wire logic                 rtv_valid_i,
  input  wire logic [7:0]           rtv_addr_i,
  input  wire logic [CUR_W-1:0]     rtv_data_i,
  input  wire logic [7:0]           rtv_base_i,
  output logic [N_MAG*CUR_W-1:0]    magnet_current_o,
  output logic                      current_update_o,
  // Scanning converter
  output logic                      sample_hold_o,
  output logic [2:0]                adc_channel_o,
  output logic                      adc_start_o,
  input  wire logic                 adc_done_i,
  input  wire logic [SAMPLE_W-1:0]  adc_data_i,
  output logic [1:0]                gain_sel_o,
  // Processor side of the FIFO
  output logic                      fifo_valid_o,
  input  wire logic                 fifo_ready_i,
  output logic [WORD_W-1:0]         fifo_data_o,
  output logic                      open_tap_o,
  // Processor control
  input  wire logic                 adc_wd_kick_i,
  input  wire logic                 dout_wd_kick_i,
  input  wire logic                 fault_req_i,
  input  wire logic                 quench_clear_i,
  input  wire logic                 bipolar_en_i,
  input  wire logic                 sextupole_en_i,
  input  wire logic                 heater_en_i,
  // Outputs to the permit module and supplies
  output logic                      quench_o,
  output logic                      bipolar_en_o,
  output logic                      sextupole_en_o,
  output logic                      heater_en_o,
  output logic                      heater_fire_o,
  output logic                      overrun_o
);
  typedef enum logic [1:0] {QDA_IDLE, QDA_CONV, QDA_WAIT, QDA_PUSH} qda_state_t;

  // Strobe inputs are synchronised: two flops, the first read only by the second; data inputs get one flop
  logic [1:0] evt_v_s;
  logic [1:0] adc_done_s;
  logic [1:0] rtv_v_s;
  logic       evt_v_q;
  logic       rtv_v_q;
  logic [7:0] evt_code_q;
  logic [7:0] rtv_addr_q;
  logic [CUR_W-1:0]    rtv_data_q;
  logic [SAMPLE_W-1:0] adc_data_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_v_s    <= '0;
      adc_done_s <= '0;
      rtv_v_s    <= '0;
      evt_v_q    <= 1'b0;
      rtv_v_q    <= 1'b0;
      evt_code_q <= '0;
      rtv_addr_q <= '0;
      rtv_data_q <= '0;
      adc_data_q <= '0;
    end else begin
      evt_v_s    <= {evt_v_s[0], evt_valid_i};
      adc_done_s <= {adc_done_s[0], adc_done_i};
      rtv_v_s    <= {rtv_v_s[0], rtv_valid_i};
      evt_v_q    <= evt_v_s[1];
      rtv_v_q    <= rtv_v_s[1];
      // Data is held stable by the source across its strobe
      evt_code_q <= evt_code_i;
      rtv_addr_q <= rtv_addr_i;
      rtv_data_q <= rtv_data_i;
      adc_data_q <= adc_data_i;
    end
  end

  logic evt_rise;
  logic rtv_rise;
  logic done_rise;
  logic done_d;
  assign evt_rise  = evt_v_s[1] && !evt_v_q;
  assign rtv_rise  = rtv_v_s[1] && !rtv_v_q;
  assign done_rise = adc_done_s[1] && !done_d;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_d <= 1'b0;
    end else begin
      done_d <= adc_done_s[1];
    end
  end

  // Strobe timing: free-runs at 720 Hz, re-phased by each clock event
  logic [31:0] period_cnt;
  logic        strobe;
  assign strobe = (evt_rise && evt_code_q == EVT_CLK720) ||
                  (period_cnt >= 32'(STROBE_CY - 1));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      period_cnt    <= '0;
      sample_hold_o <= 1'b0;
    end else begin
      period_cnt    <= strobe ? '0 : period_cnt + 32'h1;
      sample_hold_o <= strobe;
    end
  end

  // Scan sequencer
  qda_state_t          state;
  logic [2:0]          chan;
  logic [31:0]         conv_cnt;
  logic                push_valid;
  logic                push_ready;
  logic [WORD_W-1:0]   push_word;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state         <= QDA_IDLE;
      chan          <= '0;
      conv_cnt      <= '0;
      adc_start_o   <= 1'b0;
      adc_channel_o <= '0;
      push_valid    <= 1'b0;
      push_word     <= '0;
      overrun_o     <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      if (strobe && state != QDA_IDLE) begin
        overrun_o <= 1'b1;
      end else if (quench_clear_i) begin
        overrun_o <= 1'b0;
      end
      case (state)
        QDA_IDLE: begin
          if (strobe) begin
            chan          <= '0;
            adc_channel_o <= '0;
            adc_start_o   <= 1'b1;
            conv_cnt      <= '0;
            state         <= QDA_CONV;
          end
        end
        QDA_CONV: begin
          // Fixed slot per channel keeps the scan rate deterministic
          conv_cnt <= conv_cnt + 32'h1;
          if (done_rise) begin
            push_word  <= {open_tap_status(adc_data_q), 4'h0, chan, adc_data_q};
          end
          if (conv_cnt >= 32'(CONV_CY - 1)) begin
            state <= QDA_PUSH;
          end
        end
        QDA_PUSH: begin
          push_valid <= 1'b1;
          state      <= QDA_WAIT;
        end
        QDA_WAIT: begin
          // Back-pressure from the FIFO stalls the scan
          if (push_valid && push_ready) begin
            push_valid <= 1'b0;
            if (chan == 3'(N_CH - 1)) begin
              state <= QDA_IDLE;
            end else begin
              chan          <= chan + 3'h1;
              adc_channel_o <= chan + 3'h1;
              adc_start_o   <= 1'b1;
              conv_cnt      <= '0;
              state         <= QDA_CONV;
            end
          end
        end
        default: state <= QDA_IDLE;
      endcase
    end
  end

  // Status byte: open-tap flag on top bit
  function automatic logic open_tap_status(input logic [SAMPLE_W-1:0] s);
    open_tap_status = s[SAMPLE_W-1];
  endfunction : open_tap_status

  logic f_valid;
  logic [WORD_W-1:0] f_data;
  qda_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_word),
    .out_valid_o (f_valid),
    // Pop exactly when the output register loads, so no word is shown twice
    .out_ready_i (!fifo_valid_o),
    .out_data_o  (f_data)
  );

  // Registered output stage; one word per two cycles is well inside 80 ns
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fifo_valid_o <= 1'b0;
      fifo_data_o  <= '0;
      open_tap_o   <= 1'b0;
    end else begin
      if (fifo_valid_o && fifo_ready_i) begin
        fifo_valid_o <= 1'b0;
      end else if (f_valid && !fifo_valid_o) begin
        fifo_valid_o <= 1'b1;
        fifo_data_o  <= f_data;
        open_tap_o   <= f_data[WORD_W-1];
      end
    end
  end

  // Current extraction from the real-time value link
  genvar g;
  generate
    for (g = 0; g < N_MAG; g++) begin : g_cur
      always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          magnet_current_o[g*CUR_W +: CUR_W] <= '0;
        end else if (rtv_rise && rtv_addr_q == rtv_base_i + 8'(g)) begin
          magnet_current_o[g*CUR_W +: CUR_W] <= rtv_data_q;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      current_update_o <= 1'b0;
    end else begin
      current_update_o <= rtv_rise && rtv_addr_q >= rtv_base_i &&
                          rtv_addr_q < rtv_base_i + 8'(N_MAG);
    end
  end

  // Watchdogs
  logic adc_wd_exp;
  logic dout_wd_exp;
  qda_watchdog #(
    .TIMEOUT (ADC_WD_CY)
  ) u_adc_wd (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .kick_i    (adc_wd_kick_i),
    .clear_i   (quench_clear_i),
    .expired_o (adc_wd_exp)
  );
  qda_watchdog #(
    .TIMEOUT (DOUT_WD_CY)
  ) u_dout_wd (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .kick_i    (dout_wd_kick_i),
    .clear_i   (quench_clear_i),
    .expired_o (dout_wd_exp)
  );

  // Quench latch: set beats clear so a fault in the clear cycle survives
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quench_o <= 1'b0;
    end else if (fault_req_i || adc_wd_exp) begin
      quench_o <= 1'b1;
    end else if (quench_clear_i) begin
      quench_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gain_sel_o <= GAIN_NORMAL;
    end else begin
      gain_sel_o <= (quench_o || fault_req_i) ? GAIN_QUENCH : GAIN_NORMAL;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bipolar_en_o   <= 1'b0;
      sextupole_en_o <= 1'b0;
      heater_en_o    <= 1'b0;
      heater_fire_o  <= 1'b0;
    end else begin
      bipolar_en_o   <= bipolar_en_i;
      sextupole_en_o <= sextupole_en_i;
      heater_en_o    <= heater_en_i || dout_wd_exp;
      heater_fire_o  <= dout_wd_exp;
    end
  end
endmodule : qda_acq
`default_nettype wire

// file: bench/qda_acq_sva.sv
// Port-level assertions for the quench detect acquisition block
`timescale 1ns/1ps
`default_nettype none
module qda_acq_sva
  import qda_pkg::*;
#(
  parameter int unsigned CONV_CY    = 20,
  parameter int unsigned ADC_WD_CY  = 200,
  parameter int unsigned DOUT_WD_CY = 50
) (
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  input wire logic              evt_valid_i,
  input wire logic [7:0]        evt_code_i,
  input wire logic              sample_hold_o,
  input wire logic [2:0]        adc_channel_o,
  input wire logic              adc_start_o,
  input wire logic              fifo_valid_o,
  input wire logic              fifo_ready_i,
  input wire logic [WORD_W-1:0] fifo_data_o,
  input wire logic              adc_wd_kick_i,
  input wire logic              dout_wd_kick_i,
  input wire logic              fault_req_i,
  input wire logic              quench_clear_i,
  input wire logic              bipolar_en_i,
  input wire logic              sextupole_en_i,
  input wire logic              quench_o,
  input wire logic              bipolar_en_o,
  input wire logic              sextupole_en_o,
  input wire logic              heater_en_o,
  input wire logic              heater_fire_o,
  input wire logic              overrun_o,
  input wire logic [1:0]        gain_sel_o
);
  int unsigned scnt;
  int unsigned acnt;
  int unsigned dcnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) scnt <= 0;
    else if (adc_start_o) scnt <= 0;
    else if (scnt < 100000) scnt <= scnt + 1;
  end
  // Clear also restarts these counts, which only loosens the watchdog checks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) acnt <= 0;
    else if (adc_wd_kick_i || quench_clear_i) acnt <= 0;
    else if (acnt < 100000) acnt <= acnt + 1;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) dcnt <= 0;
    else if (dout_wd_kick_i || quench_clear_i) dcnt <= 0;
    else if (dcnt < 100000) dcnt <= dcnt + 1;
  end
  a_strobe_scan: assert property (sample_hold_o |-> (adc_start_o && adc_channel_o == 3'h0) || overrun_o)
    else $error("scan did not start with the strobe");
  a_event_strobe: assert property ($rose(evt_valid_i) && evt_code_i == EVT_CLK720 |-> ##3 (sample_hold_o || overrun_o))
    else $error("clock event gave no strobe");
  a_conv_spacing: assert property (adc_start_o && !sample_hold_o |-> scnt >= CONV_CY)
    else $error("channel slot too short");
  a_fifo_hold: assert property (fifo_valid_o && !fifo_ready_i |=> fifo_valid_o && $stable(fifo_data_o))
    else $error("word changed before it was taken");
  a_quench_set: assert property (fault_req_i |=> quench_o)
    else $error("fault request did not raise quench");
  a_quench_latch: assert property (quench_o && !quench_clear_i |=> quench_o)
    else $error("quench dropped without clear");
  a_gain_follow: assert property (1'b1 |=> gain_sel_o == (($past(quench_o) || $past(fault_req_i)) ? GAIN_QUENCH : GAIN_NORMAL))
    else $error("gain select wrong");
  a_enable_follow: assert property ($past(reset_n_i) |-> bipolar_en_o == $past(bipolar_en_i) && sextupole_en_o == $past(sextupole_en_i))
    else $error("supply enable did not follow");
  a_adc_watchdog: assert property (acnt == ADC_WD_CY + 3 |-> quench_o)
    else $error("converter watchdog did not quench");
  a_dout_watchdog: assert property (dcnt == DOUT_WD_CY + 3 |-> heater_fire_o && heater_en_o)
    else $error("output watchdog did not fire heaters");
endmodule : qda_acq_sva
`default_nettype wire

// file: bench/qda_adc_model.sv
// Behavioural scanning converter on the far side of the block
`timescale 1ns/1ps
`default_nettype none
module qda_adc_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        start_i,
  input  wire logic [2:0]  chan_i,
  input  wire logic        slow_i,
  input  wire logic        neg_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  int          cnt;
  logic [15:0] word;
  // Slow answer still ends inside the slot so the last done edge is this word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      word <= 16'h0;
    end else if (start_i) begin
      cnt <= slow_i ? 16 : 6;
      word <= {neg_i, 4'h0, chan_i, 8'h3c};
    end else if (cnt > 0) cnt <= cnt - 1;
  end
  assign done_o = cnt > 0 && cnt <= 4;
  // Outside the hold window the data shows the inverse, never the last word
  assign data_o = done_o ? word : ~word;
endmodule : qda_adc_model
`default_nettype wire

// file: bench/tb_qda_acq.sv
// Self-checking testbench for the quench detect acquisition block
`timescale 1ns/1ps
`default_nettype none
module tb_qda_acq;
  import qda_pkg::*;
  typedef struct packed {logic [7:0] addr; logic [15:0] data; logic hit; logic [2:0] en;} qda_row_t;
  logic        clk_i, reset_n_i, evt_valid_i, rtv_valid_i, adc_done_i, fifo_ready_i, fault_req_i, quench_clear_i;
  logic        adc_wd_kick_i, dout_wd_kick_i, bipolar_en_i, sextupole_en_i, heater_en_i, slow, neg, kick_on, dkick_on;
  logic        current_update_o, sample_hold_o, adc_start_o, fifo_valid_o, open_tap_o, quench_o, bipolar_en_o;
  logic        sextupole_en_o, heater_en_o, heater_fire_o, overrun_o, upd;
  logic [7:0]  evt_code_i, rtv_addr_i, rtv_base_i;
  logic [15:0] rtv_data_i, adc_data_i;
  logic [63:0] magnet_current_o, mag_exp;
  logic [23:0] fifo_data_o;
  logic [2:0]  adc_channel_o;
  logic [1:0]  gain_sel_o;
  int          error_cnt, samples_checked, kc;
  qda_row_t    rows [5] = '{'{8'h10, 16'h1234, 1'b1, 3'b101}, '{8'h13, 16'hfedc, 1'b1, 3'b010},
                            '{8'h14, 16'h5555, 1'b0, 3'b111}, '{8'h0f, 16'haaaa, 1'b0, 3'b011},
                            '{8'h11, 16'h0001, 1'b1, 3'b000}};
  qda_acq #(.STROBE_CY(3000), .CONV_CY(20), .ADC_WD_CY(200), .DOUT_WD_CY(50)) u_qda_acq (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .evt_valid_i(evt_valid_i), .evt_code_i(evt_code_i),
    .rtv_valid_i(rtv_valid_i), .rtv_addr_i(rtv_addr_i), .rtv_data_i(rtv_data_i), .rtv_base_i(rtv_base_i),
    .magnet_current_o(magnet_current_o), .current_update_o(current_update_o), .sample_hold_o(sample_hold_o),
    .adc_channel_o(adc_channel_o), .adc_start_o(adc_start_o), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
    .gain_sel_o(gain_sel_o), .fifo_valid_o(fifo_valid_o), .fifo_ready_i(fifo_ready_i), .fifo_data_o(fifo_data_o),
    .open_tap_o(open_tap_o), .adc_wd_kick_i(adc_wd_kick_i), .dout_wd_kick_i(dout_wd_kick_i),
    .fault_req_i(fault_req_i), .quench_clear_i(quench_clear_i), .bipolar_en_i(bipolar_en_i),
    .sextupole_en_i(sextupole_en_i), .heater_en_i(heater_en_i), .quench_o(quench_o), .bipolar_en_o(bipolar_en_o),
    .sextupole_en_o(sextupole_en_o), .heater_en_o(heater_en_o), .heater_fire_o(heater_fire_o),
    .overrun_o(overrun_o));
  qda_adc_model u_qda_adc_model (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(adc_start_o),
    .chan_i(adc_channel_o), .slow_i(slow), .neg_i(neg), .done_o(adc_done_i), .data_o(adc_data_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Processor restarts both watchdogs well inside their periods
  always @(negedge clk_i) begin
    kc <= kc + 1;
    adc_wd_kick_i <= kick_on && (kc % 50 == 0);
    dout_wd_kick_i <= dkick_on && (kc % 20 == 0);
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  function automatic logic pick(input int s);
    case (s)
      0: return sample_hold_o;
      1: return fifo_valid_o;
      2: return quench_o;
      default: return heater_fire_o;
    endcase
  endfunction : pick
  task automatic wait_hi(input int s, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk_i);
      if (pick(s) === 1'b1) return;
    end
    error_cnt++;
    $display("[ERR] %0t wait ran out on %0d", $time, s);
    stop_test();
  endtask : wait_hi
  task automatic send_evt(input logic [7:0] code);
    @(negedge clk_i);
    evt_code_i = code;
    evt_valid_i = 1'b1;
    repeat (3) @(negedge clk_i);
    evt_valid_i = 1'b0;
  endtask : send_evt
  task automatic pulse_clear();
    @(negedge clk_i);
    quench_clear_i = 1'b1;
    @(negedge clk_i);
    quench_clear_i = 1'b0;
  endtask : pulse_clear
  task automatic drain(input logic n);
    for (int c = 0; c < 8; c++) begin
      wait_hi(1, 400);
      chk(64'(fifo_data_o), 64'({n, 4'h0, c[2:0], n, 4'h0, c[2:0], 8'h3c}));
      chk(64'(open_tap_o), 64'(n));
      // Ready only for one cycle, so a word taken twice would show up
      fifo_ready_i = 1'b1;
      @(negedge clk_i);
      fifo_ready_i = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    chk(64'(fifo_valid_o), 64'h0);
  endtask : drain
  initial begin
    {evt_valid_i, rtv_valid_i, fifo_ready_i, fault_req_i, quench_clear_i, bipolar_en_i} = '0;
    {sextupole_en_i, heater_en_i, slow, neg, kick_on, dkick_on, reset_n_i} = '0;
    {evt_code_i, rtv_addr_i, rtv_data_i, mag_exp} = '0;
    rtv_base_i = 8'h10;
    error_cnt = 0;
    samples_checked = 0;
    kc = 0;
    repeat (10) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    chk(64'({quench_o, heater_fire_o, overrun_o, fifo_valid_o, sample_hold_o, gain_sel_o}), 64'h0);
    kick_on = 1'b1;
    dkick_on = 1'b1;
    repeat (2) @(negedge clk_i);
    foreach (rows[i]) begin
      @(negedge clk_i);
      {bipolar_en_i, sextupole_en_i, heater_en_i} = rows[i].en;
      rtv_addr_i = rows[i].addr;
      rtv_data_i = rows[i].data;
      rtv_valid_i = 1'b1;
      upd = 1'b0;
      for (int k = 0; k < 8; k++) begin
        @(negedge clk_i);
        if (k == 2) rtv_valid_i = 1'b0;
        upd |= current_update_o;
      end
      if (rows[i].hit) mag_exp[(int'(rows[i].addr) - 16) * 16 +: 16] = rows[i].data;
      chk(64'(upd), 64'(rows[i].hit));
      chk(magnet_current_o, mag_exp);
      chk(64'({bipolar_en_o, sextupole_en_o, heater_en_o}), 64'(rows[i].en));
    end
    send_evt(EVT_CLK720);
    // The strobe pulse stands only in the cycle in which the event call returns
    chk(64'({sample_hold_o, adc_start_o, adc_channel_o}), 64'h18);
    send_evt(8'h02);
    chk(64'(overrun_o), 64'h0);
    send_evt(EVT_CLK720);
    repeat (4) @(negedge clk_i);
    chk(64'(overrun_o), 64'h1);
    repeat (300) @(negedge clk_i);
    drain(1'b0);
    pulse_clear();
    chk(64'(overrun_o), 64'h0);
    slow = 1'b1;
    neg = 1'b1;
    wait_hi(0, 3100);
    drain(1'b1);
    fault_req_i = 1'b1;
    @(negedge clk_i);
    fault_req_i = 1'b0;
    chk(64'(quench_o), 64'h1);
    repeat (2) @(negedge clk_i);
    chk(64'(gain_sel_o), 64'(GAIN_QUENCH));
    quench_clear_i = 1'b1;
    fault_req_i = 1'b1;
    @(negedge clk_i);
    quench_clear_i = 1'b0;
    fault_req_i = 1'b0;
    chk(64'(quench_o), 64'h1);
    pulse_clear();
    repeat (2) @(negedge clk_i);
    chk(64'({quench_o, gain_sel_o}), 64'(GAIN_NORMAL));
    kick_on = 1'b0;
    repeat (140) @(negedge clk_i);
    chk(64'(quench_o), 64'h0);
    wait_hi(2, 120);
    kick_on = 1'b1;
    repeat (60) @(negedge clk_i);
    // Expiry latch is still set at the first clear, and set wins over clear
    pulse_clear();
    chk(64'(quench_o), 64'h1);
    pulse_clear();
    chk(64'(quench_o), 64'h0);
    dkick_on = 1'b0;
    repeat (25) @(negedge clk_i);
    chk(64'(heater_fire_o), 64'h0);
    wait_hi(3, 60);
    chk(64'(heater_en_o), 64'h1);
    dkick_on = 1'b1;
    repeat (25) @(negedge clk_i);
    pulse_clear();
    // Fire output is registered, so it drops one cycle after the latch
    @(negedge clk_i);
    chk(64'(heater_fire_o), 64'h0);
    stop_test();
  end
endmodule : tb_qda_acq
bind qda_acq qda_acq_sva #(.CONV_CY(CONV_CY), .ADC_WD_CY(ADC_WD_CY), .DOUT_WD_CY(DOUT_WD_CY)) u_qda_acq_sva (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .evt_valid_i(evt_valid_i), .evt_code_i(evt_code_i),
  .sample_hold_o(sample_hold_o), .adc_channel_o(adc_channel_o), .adc_start_o(adc_start_o),
  .fifo_valid_o(fifo_valid_o), .fifo_ready_i(fifo_ready_i), .fifo_data_o(fifo_data_o),
  .adc_wd_kick_i(adc_wd_kick_i), .dout_wd_kick_i(dout_wd_kick_i), .fault_req_i(fault_req_i),
  .quench_clear_i(quench_clear_i), .bipolar_en_i(bipolar_en_i), .sextupole_en_i(sextupole_en_i),
  .quench_o(quench_o), .bipolar_en_o(bipolar_en_o), .sextupole_en_o(sextupole_en_o), .heater_en_o(heater_en_o),
  .heater_fire_o(heater_fire_o), .overrun_o(overrun_o), .gain_sel_o(gain_sel_o));
`default_nettype wire
